//--- src/clock_halt_restart_control.sv
// top of the clock halt and restart controller with its AHB-Lite registers
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module clock_halt_restart_control #(
  parameter int SETTLE_CYCLES = clk_halt_pkg::SETTLE_COUNT,
  parameter int PRESCALE      = clk_halt_pkg::SLOW_PRESCALE
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  // oscillator and frequency source pins
  input  wire logic        CRYSTAL_IN,
  output logic             CRYSTAL_OUT,
  input  wire logic        OSC_VALID,
  output logic             OSC_OUT,
  input  wire logic        EXT_FREQ_IN,
  input  wire logic        SOURCE_SELECT,
  input  wire logic        SPEED_SELECT,
  // processor status and restart pins
  input  wire logic        START,
  input  wire logic        STATUS_BIT_ZERO,
  input  wire logic        STATUS_BIT_ONE,
  input  wire logic        HALT_STATUS_N,
  input  wire logic        RESET_REQUEST_N,
  // generated clocks
  output logic             PROC_CLOCK,
  output logic             HALF_DUTY_CLOCK,
  output logic             PERIPH_CLOCK,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA
);
  import clk_halt_pkg::*;

  // timing overview
  // every change of the selected source level is one half-step;
  // the wave generator turns half-steps into the three clocks.
  // fast mode: six half-steps per processor period.
  // slow mode: the phase moves once per prescale of half-steps.
  // the peripheral clock never looks at the speed select.
  // outputs lag the source edge by one system clock, since the
  // source is sampled like any other synchronous input.
  // hazard: source edges faster than half the system clock
  // are lost, so the source must stay well below it.
  // the halt freezes the wave generator and forces the processor
  // and half duty clocks high; the peripheral clock keeps its level.
  // the oscillator is modelled as an enable plus a registered
  // inverter; the real amplifier sits outside this logic.
  // a stopped oscillator presents a steady high source level,
  // so the divider sees no spurious half-steps while halted.
  // limitation: the threshold crossing is only an input here,
  // the analog detector lives with the amplifier.
  //
  // all control state in one record
  typedef struct packed {
    ctl_state_t  state;     // settling, running or halted
    logic        osc_run;   // oscillator enabled
    logic        passive;   // previous sampled code was passive
    logic        start_d;   // combined start level, last cycle
    logic        src_d;     // selected source level, last cycle
    logic        xtal_d;    // crystal level, last cycle
    logic        sw_start;  // software start level
    logic        wr_pend;   // write data phase pending
    logic [7:0]  wr_addr;   // offset of the pending write
    logic [31:0] rdata;     // read data for the data phase
    logic        osc_out;   // registered oscillator monitor
    logic        xtal_out;  // registered oscillator drive
  } ctl_t;

  ctl_t cur_ff, nxt_st;

  // helper signals of the combinational process
  logic       ext_mode;     // external frequency source chosen
  logic       start_lvl;    // pin start or software start
  logic       start_rise;   // start went high this cycle
  logic       restart;      // any restart request
  logic       src_lvl;      // level of the selected source
  logic       step;         // one half-step of the source
  logic       xtal_tick;    // crystal rising edge
  logic [2:0] status_code;  // sampled processor status lines
  logic       addr_ok;      // valid AHB address phase
  logic [31:0] status_word; // live status register value

  // outputs of the leaf modules
  logic proc_clk;
  logic half_clk;
  logic periph_clk;
  logic proc_rise;
  logic fast_active;
  logic settle_done;

  // status register layout, built from live state
  function automatic logic [31:0] make_status(input ctl_t s, input logic fast,
                                              input logic ext);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ST_HALTED_BIT]  = (s.state == ST_HALTED);
    w[ST_SETTLE_BIT]  = (s.state == ST_SETTLE);
    w[ST_OSC_RUN_BIT] = s.osc_run;
    w[ST_FAST_BIT]    = fast;
    w[ST_EXT_BIT]     = ext;
    w[ST_START_BIT]   = s.sw_start;
    return w;
  endfunction

  // halt detection
  // the status lines are looked at once per processor period,
  // in the cycle that the wave generator flags the clock rise.
  // a passive code at one rise arms the detector; a halt code
  // at the very next rise then stops the clocks.
  // any other code disarms it, so a stray halt code alone
  // never stops anything.
  // a high start level, from the pin or from software, keeps
  // the detector from acting at all.
  // restart
  // a rising start level or a low reset request wakes the block.
  // external mode goes straight back to running; crystal mode
  // first enables the oscillator and waits for the settle count.
  // the speed in force is kept inside the wave generator, so a
  // restart comes back at the speed it stopped with.
  // trade-off: a reset request with the oscillator already on
  // does not retrigger settling, to avoid a needless long stall.
  //
  // control process: source, halt detection, restart and register file
  always_comb begin
    nxt_st = cur_ff;
    // source select is taken as a steady level
    ext_mode = SOURCE_SELECT;
    // a stopped oscillator presents a steady high level
    src_lvl = ext_mode ? EXT_FREQ_IN : (cur_ff.osc_run ? CRYSTAL_IN : 1'b1);
    step = (src_lvl != cur_ff.src_d);
    nxt_st.src_d = src_lvl;
    // crystal edges feed the settling counter only while enabled
    xtal_tick = cur_ff.osc_run && CRYSTAL_IN && !cur_ff.xtal_d;
    nxt_st.xtal_d = CRYSTAL_IN;
    // start pin and software start act alike
    start_lvl = START || cur_ff.sw_start;
    start_rise = start_lvl && !cur_ff.start_d;
    nxt_st.start_d = start_lvl;
    restart = start_rise || !RESET_REQUEST_N;
    status_code = {HALT_STATUS_N, STATUS_BIT_ONE, STATUS_BIT_ZERO};

    case (cur_ff.state)
      ST_SETTLE: begin
        // external source needs no settling: resumes on the next half-step
        if (ext_mode) begin
          nxt_st.state = ST_RUN;
        end else if (settle_done) begin
          nxt_st.state = ST_RUN;
        end
        nxt_st.passive = 1'b0;
      end
      ST_RUN: begin
        // status looked at only on the processor clock rise
        if (proc_rise) begin
          nxt_st.passive = (status_code == STATUS_PASSIVE);
          // any other code keeps the clocks going
          if ((status_code == STATUS_HALT) && cur_ff.passive
              && !start_lvl) begin
            nxt_st.state = ST_HALTED;
            // crystal mode stops the oscillator as well
            if (!ext_mode) begin
              nxt_st.osc_run = 1'b0;
            end
          end
        end
      end
      ST_HALTED: begin
        nxt_st.passive = 1'b0;
        if (restart) begin
          if (!ext_mode && !cur_ff.osc_run) begin
            // oscillator must come up and settle first
            nxt_st.osc_run = 1'b1;
            nxt_st.state = ST_SETTLE;
          end else begin
            nxt_st.state = ST_RUN;
          end
        end
      end
      default: begin
        nxt_st.state = ST_SETTLE;
      end
    endcase

    // reset request also starts the oscillator in any state
    if (!RESET_REQUEST_N && !cur_ff.osc_run) begin
      nxt_st.osc_run = 1'b1;
      if (!ext_mode) begin
        nxt_st.state = ST_SETTLE;
      end
    end

    // oscillator monitor rests high once the oscillator stops
    nxt_st.osc_out = nxt_st.osc_run ? CRYSTAL_IN : 1'b1;
    // drive is the inverted input while the amplifier runs
    nxt_st.xtal_out = nxt_st.osc_run ? ~CRYSTAL_IN : 1'b1;

    // register map
    // control word: bit zero is the software start level; it acts
    // exactly like the start pin and stays set until cleared.
    // status word: halted, settling, oscillator enabled, fast in
    // force, external mode and the software start level.
    // unmapped reads return zero; unmapped writes are dropped.
    // the slave never stalls, so the address of a write is kept
    // for one cycle and its data taken in the data phase.
    // read data is captured in the address phase and held until
    // the next read, which keeps the data output registered.
    // size and burst qualifiers are ignored: single words only.
    //
    // AHB-Lite: write data lands one cycle after its address phase
    addr_ok = HSEL && HTRANS[1] && HREADY;
    status_word = make_status(cur_ff, fast_active, ext_mode);
    if (cur_ff.wr_pend && (cur_ff.wr_addr == CTRL_OFFSET)) begin
      nxt_st.sw_start = HWDATA[CTRL_START_BIT];
    end
    nxt_st.wr_pend = addr_ok && HWRITE;
    nxt_st.wr_addr = HADDR[7:0];
    // read data registered in the address phase, zero when unmapped
    if (addr_ok && !HWRITE) begin
      if (HADDR[7:0] == CTRL_OFFSET) begin
        nxt_st.rdata = 32'h0000_0000;
        nxt_st.rdata[CTRL_START_BIT] = cur_ff.sw_start;
      end else if (HADDR[7:0] == STATUS_OFFSET) begin
        nxt_st.rdata = status_word;
      end else begin
        nxt_st.rdata = 32'h0000_0000;
      end
    end
  end

  // reset puts the block in settling with the oscillator on,
  // so a crystal system always waits the full count at power-up,
  // while an external source runs from the next edge.
  // the software start level comes from the control reset value.
  //
  // state register; after reset the oscillator starts and settles
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cur_ff <= '{state: ST_SETTLE, osc_run: 1'b1, passive: 1'b0,
                  start_d: 1'b0, src_d: 1'b1, xtal_d: 1'b0,
                  sw_start: CTRL_RESET[CTRL_START_BIT], wr_pend: 1'b0,
                  wr_addr: 8'h00, rdata: 32'h0000_0000,
                  osc_out: 1'b1, xtal_out: 1'b1};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // the wave generator owns the divider phase, the prescaler and
  // the speed in force; it only moves on a source half-step while
  // the run input is high, and a speed change waits for the start
  // of a processor period so that no clock pulse is cut short.
  //
  // clock waves run only in the run state; halt freezes them
  clock_wave_gen #(
    .PRESCALE (PRESCALE)
  ) u_wave (
    .CLK         (CLK),
    .NRST        (NRST),
    .step        (step),
    .run         (cur_ff.state == ST_RUN),
    .fast        (SPEED_SELECT),
    .proc_clk    (proc_clk),
    .half_clk    (half_clk),
    .periph_clk  (periph_clk),
    .proc_rise   (proc_rise),
    .fast_active (fast_active)
  );

  // the settle counter counts crystal rising edges while the
  // oscillator is enabled and the valid input is high; it is held
  // clear whenever the oscillator is off, so each restart waits
  // the whole count even after a short stop.
  //
  // counter cleared while the oscillator is off
  settle_counter #(
    .COUNT (SETTLE_CYCLES)
  ) u_settle (
    .CLK       (CLK),
    .NRST      (NRST),
    .clear     (!cur_ff.osc_run),
    .osc_tick  (xtal_tick),
    .osc_valid (OSC_VALID),
    .done      (settle_done)
  );

  // outputs straight from flip-flops
  assign PROC_CLOCK      = proc_clk;
  assign HALF_DUTY_CLOCK = half_clk;
  assign PERIPH_CLOCK    = periph_clk;
  assign OSC_OUT         = cur_ff.osc_out;
  assign CRYSTAL_OUT     = cur_ff.xtal_out;
  // zero-wait slave, always OKAY
  assign HREADYOUT       = 1'b1;
  assign HRESP           = 1'b0;
  assign HRDATA          = cur_ff.rdata;
endmodule // clock_halt_restart_control
`default_nettype wire

//--- include/clk_halt_pkg.sv
// shared constants and types for the clock halt and restart controller
package clk_halt_pkg;
  // register byte offsets on the AHB-Lite slave
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // control register bit positions
  localparam int CTRL_START_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status register bit positions
  localparam int ST_HALTED_BIT  = 0;
  localparam int ST_SETTLE_BIT  = 1;
  localparam int ST_OSC_RUN_BIT = 2;
  localparam int ST_FAST_BIT    = 3;
  localparam int ST_EXT_BIT     = 4;
  localparam int ST_START_BIT   = 5;
  // status line codes, ordered {halt_status_n, status_bit_one, status_bit_zero}
  localparam logic [2:0] STATUS_PASSIVE = 3'h7;
  localparam logic [2:0] STATUS_HALT    = 3'h3;
  // half-steps of the source per processor clock period, fast mode (divide by 3)
  localparam int PROC_HALF_STEPS = 6;
  // processor clock high for the first steps, half duty clock for the next
  localparam int PROC_HIGH_STEPS = 2;
  localparam int HALF_HIGH_STEPS = 3;
  // half-steps per peripheral clock level (divide by 6 overall)
  localparam int PERIPH_LEVEL_STEPS = 6;
  // slow mode prescale: 3 x 256 = 768
  localparam int SLOW_PRESCALE = 256;
  // oscillator settling count, 8K oscillator cycles
  localparam int SETTLE_COUNT = 8192;
  // top-level control states
  typedef enum logic [1:0] {ST_SETTLE, ST_RUN, ST_HALTED} ctl_state_t;
endpackage

//--- src/settle_counter.sv
// oscillator settling counter that gates restart in crystal mode
`timescale 1ns/1ps
`default_nettype none
module settle_counter #(
  parameter int COUNT = clk_halt_pkg::SETTLE_COUNT
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic clear,
  input  wire logic osc_tick,
  input  wire logic osc_valid,
  output logic      done
);
  import clk_halt_pkg::*;
  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  typedef struct packed {
    logic [W-1:0] cnt;  // oscillator cycles seen so far
    logic         done; // terminal count reached
  } settle_t;

  settle_t cur_ff, nxt_st;

  // counting only starts once the input crosses its threshold
  always_comb begin
    nxt_st = cur_ff;
    if (clear) begin
      nxt_st = '0;
    end else if (osc_tick && osc_valid && !cur_ff.done) begin
      if (cur_ff.cnt == LAST) begin
        nxt_st.done = 1'b1;
      end else begin
        nxt_st.cnt = cur_ff.cnt + W'(1);
      end
    end
  end

  // state register, synchronous reset
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign done = cur_ff.done;
endmodule // settle_counter
`default_nettype wire

//--- src/clock_wave_gen.sv
// divider making the processor, half duty and peripheral clock waves
`timescale 1ns/1ps
`default_nettype none
module clock_wave_gen #(
  parameter int PRESCALE = clk_halt_pkg::SLOW_PRESCALE
) (
  input  wire logic CLK,
  input  wire logic NRST,
  input  wire logic step,
  input  wire logic run,
  input  wire logic fast,
  output logic      proc_clk,
  output logic      half_clk,
  output logic      periph_clk,
  output logic      proc_rise,
  output logic      fast_active
);
  import clk_halt_pkg::*;

  typedef struct packed {
    logic [7:0] pre;   // slow mode prescaler
    logic [2:0] phase; // half-step within the processor period
    logic [2:0] pstep; // half-steps within a peripheral level
    logic       fast;  // speed in force, changed only at period start
    logic       proc;
    logic       half;
    logic       pclk;
    logic       rise;  // pulse: processor clock just went high
  } wave_t;

  wave_t cur_ff, nxt_st;
  logic  adv; // processor divider advances this step

  always_comb begin
    nxt_st = cur_ff;
    nxt_st.rise = 1'b0;
    adv = cur_ff.fast || (cur_ff.pre == 8'(PRESCALE - 1));
    if (run && step) begin
      // peripheral clock ignores speed select
      if (cur_ff.pstep == 3'(PERIPH_LEVEL_STEPS - 1)) begin
        nxt_st.pstep = '0;
        nxt_st.pclk = ~cur_ff.pclk;
      end else begin
        nxt_st.pstep = cur_ff.pstep + 3'h1;
      end
      nxt_st.pre = (cur_ff.fast || adv) ? 8'h00 : cur_ff.pre + 8'h01;
      if (adv) begin
        if (cur_ff.phase == 3'(PROC_HALF_STEPS - 1)) begin
          nxt_st.phase = '0;
          nxt_st.fast = fast; // glitch-free speed change at period start
          nxt_st.rise = 1'b1;
        end else begin
          nxt_st.phase = cur_ff.phase + 3'h1;
        end
      end
    end
    // 33% processor clock, half duty clock rising as it falls
    nxt_st.proc = nxt_st.phase < 3'(PROC_HIGH_STEPS);
    nxt_st.half = (nxt_st.phase >= 3'(PROC_HIGH_STEPS)) &&
                  (nxt_st.phase < 3'(PROC_HIGH_STEPS + HALF_HIGH_STEPS));
    // halted: both held high, peripheral clock frozen, speed kept
    if (!run) begin
      nxt_st.proc = 1'b1;
      nxt_st.half = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cur_ff <= '{pre: 8'h00, phase: 3'h0, pstep: 3'h0, fast: 1'b1,
                  proc: 1'b1, half: 1'b0, pclk: 1'b0, rise: 1'b0};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign proc_clk    = cur_ff.proc;
  assign half_clk    = cur_ff.half;
  assign periph_clk  = cur_ff.pclk;
  assign proc_rise   = cur_ff.rise;
  assign fast_active = cur_ff.fast;
endmodule // clock_wave_gen
`default_nettype wire

//--- verif/clk_halt_chk_assertions.sv
// port checker for the clock halt and restart controller
`timescale 1ns/1ps
`default_nettype none
module clk_halt_chk
  import clk_halt_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_COUNT,
  parameter int PRESCALE      = SLOW_PRESCALE
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SOURCE_SELECT,
  input wire logic SPEED_SELECT,
  input wire logic START,
  input wire logic RESET_REQUEST_N,
  input wire logic STATUS_BIT_ZERO,
  input wire logic STATUS_BIT_ONE,
  input wire logic HALT_STATUS_N,
  input wire logic OSC_OUT,
  input wire logic PROC_CLOCK,
  input wire logic HALF_DUTY_CLOCK,
  input wire logic PERIPH_CLOCK
);
  logic       pc_d, st_d, hlt, xw; // delayed pins, halted and settle-wait flags
  logic [2:0] prv;                 // code seen at the previous clock rise
  int         wc, hc;              // settle-wait and high-time counters
  wire logic [2:0] code = {HALT_STATUS_N, STATUS_BIT_ONE, STATUS_BIT_ZERO};
  wire logic pr = PROC_CLOCK & ~pc_d;
  wire logic hreq = pr && code == STATUS_HALT && prv == STATUS_PASSIVE && !START;
  wire logic rs = hlt && ((START && !st_d) || !RESET_REQUEST_N);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // halt state rebuilt from the pins alone; software start is left out
  always_ff @(posedge CLK) begin
    pc_d <= PROC_CLOCK;
    st_d <= START;
    if (!NRST) begin
      prv <= 3'h0;
      hlt <= 1'h0;
      xw <= !SOURCE_SELECT;
      wc <= 0;
      hc <= 0;
    end else begin
      if (pr) prv <= code;
      hlt <= (hreq && RESET_REQUEST_N) ? 1'h1 : rs ? 1'h0 : hlt;
      hc <= (!PROC_CLOCK || hlt) ? 0 : hc + 1;
      // a crystal restart must sit through the whole settle count
      if (rs && !SOURCE_SELECT) begin
        xw <= 1'h1;
        wc <= 0;
      end else if (!PROC_CLOCK) xw <= 1'h0;
      else wc <= wc + 1;
    end
  end
  sequence frozen_s;
    (PROC_CLOCK && HALF_DUTY_CLOCK && $stable(PERIPH_CLOCK)) [*8];
  endsequence
  sequence osc_rest_s;
    (OSC_OUT && $stable(OSC_OUT)) [*8];
  endsequence
  halt_freeze_a: assert property (hreq && RESET_REQUEST_N |=> ##2 frozen_s)
    else $error("clocks not frozen after halt");
  osc_stop_a: assert property (hreq && !SOURCE_SELECT |=> ##2 osc_rest_s)
    else $error("oscillator monitor not resting high");
  osc_keeps_a: assert property (hreq && SOURCE_SELECT |-> ##[3:10] $changed(OSC_OUT))
    else $error("oscillator stopped in external mode");
  run_on_a: assert property (!hlt && !xw |-> hc <= 4 * PRESCALE + 4)
    else $error("processor clock stuck without halt");
  ext_restart_a: assert property (hlt && SOURCE_SELECT && SPEED_SELECT && $rose(START)
    |-> ##[1:14] !PROC_CLOCK)
    else $error("late restart in external mode");
  settle_wait_a: assert property ($fell(PROC_CLOCK) && xw |-> wc >= 4 * SETTLE_CYCLES - 8)
    else $error("clocks resumed before settle count");
  half_align_a: assert property ($fell(PROC_CLOCK) |-> HALF_DUTY_CLOCK)
    else $error("half duty clock not high at fall");
  periph_rate_a: assert property ($changed(PERIPH_CLOCK) |=> $stable(PERIPH_CLOCK) [*8])
    else $error("peripheral clock too fast");
endmodule // clk_halt_chk
bind clock_halt_restart_control clk_halt_chk #(.SETTLE_CYCLES(SETTLE_CYCLES),
  .PRESCALE(PRESCALE)) u_chk (.CLK, .NRST, .SOURCE_SELECT, .SPEED_SELECT, .START,
  .RESET_REQUEST_N, .STATUS_BIT_ZERO, .STATUS_BIT_ONE, .HALT_STATUS_N, .OSC_OUT,
  .PROC_CLOCK, .HALF_DUTY_CLOCK, .PERIPH_CLOCK);
`default_nettype wire

//--- verif/proc_src_model.sv
// processor status lines, crystal and external source model
`timescale 1ns/1ps
`default_nettype none
module proc_src_model (
  input  wire logic       clk,
  input  wire logic       proc_clk,
  input  wire logic       xtal_drv,
  input  wire logic       go,
  input  wire logic [2:0] lead,
  output logic            xtal,
  output logic            ext_freq_in,
  output logic            osc_ok,
  output logic [2:0]      code,
  output logic [1:0]      sq
);
  localparam logic [2:0] STOP_C = 3'h3; // halt code on the status lines
  logic ph = 1'h0; // levels last two clk cycles, slower than the sampler
  initial begin
    xtal = 1'h0;
    ext_freq_in = 1'h0;
    osc_ok = 1'h0;
    sq = 2'h0;
  end
  // crystal only swings while the drive is the inverse of its input
  always @(posedge clk) begin
    ph <= ~ph;
    if (ph) begin
      ext_freq_in <= ~ext_freq_in;
      osc_ok <= (xtal_drv == ~xtal);
      if (xtal_drv == ~xtal) xtal <= ~xtal;
    end
  end
  // the core moves its status after the clock falls: lead code, then stop code
  always @(negedge proc_clk) sq <= (sq == 2'h0) ? {1'h0, go} : (sq == 2'h1) ? 2'h2 : 2'h0;
  assign code = (sq == 2'h1) ? lead : (sq == 2'h2) ? STOP_C : 3'h6;
endmodule // proc_src_model
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the clock halt and restart controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import clk_halt_pkg::*;
  localparam int SC = 16; // shortened settle count
  localparam int PS = 4;  // shortened slow prescale
  logic clk = 1'h0, nrst = 1'h0, src = 1'h1, spd = 1'h1, start = 1'h0, rqn = 1'h1;
  logic hsel = 1'h0, hwrite = 1'h0, go = 1'h0, hrdy, hresp, proc_clk, half_clk, per_clk;
  logic osc, xo, xi, ext_freq_in, ok;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, sq;
  logic [2:0]  lead = 3'h7, code;
  int          errors = 0, total_checks = 0;
  clock_halt_restart_control #(.SETTLE_CYCLES(SC), .PRESCALE(PS)) DUT (.CLK(clk),
    .NRST(nrst), .CRYSTAL_IN(xi), .CRYSTAL_OUT(xo), .OSC_VALID(ok), .OSC_OUT(osc),
    .EXT_FREQ_IN(ext_freq_in), .SOURCE_SELECT(src), .SPEED_SELECT(spd), .START(start),
    .STATUS_BIT_ZERO(code[0]), .STATUS_BIT_ONE(code[1]), .HALT_STATUS_N(code[2]),
    .RESET_REQUEST_N(rqn), .PROC_CLOCK(proc_clk), .HALF_DUTY_CLOCK(half_clk),
    .PERIPH_CLOCK(per_clk), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp),
    .HRDATA(hrdata));
  proc_src_model PM (.clk(clk), .proc_clk(proc_clk), .xtal_drv(xo), .go(go), .lead(lead),
    .xtal(xi), .ext_freq_in(ext_freq_in), .osc_ok(ok), .code(code), .sq(sq));
  always #20 clk = ~clk;
  // single word transfer; address phase held until ready, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'h1);
    rd = hrdata;
  endtask
  function automatic logic [31:0] stv(input logic h, o, f, e);
    stv = 32'h0;
    stv[ST_HALTED_BIT] = h;
    stv[ST_OSC_RUN_BIT] = o;
    stv[ST_FAST_BIT] = f;
    stv[ST_EXT_BIT] = e;
  endfunction
  task automatic cyc_to(ref logic s, input logic lv, output int n);
    n = 0;
    while (s !== lv && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // high time and period of a clock, in system clock cycles
  task automatic per(ref logic s, output int hi, output int p);
    int b;
    cyc_to(s, 1'h0, b);
    cyc_to(s, 1'h1, b);
    cyc_to(s, 1'h0, hi);
    cyc_to(s, 1'h1, b);
    p = hi + b;
  endtask
  task automatic reset_dut(input logic s);
    @(posedge clk);
    nrst <= 1'h0;
    src <= s;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
  endtask
  // offer lead code then stop code; poll the halted flag for a while
  task automatic stop_try(input logic [2:0] l, output logic h);
    lead <= l;
    go <= 1'h1;
    wait (sq != 2'h0);
    @(posedge clk);
    go <= 1'h0;
    h = 1'h0;
    repeat (60) if (!h) begin
      bus(1'h0, STATUS_OFFSET, 32'h0);
      h = rd[ST_HALTED_BIT];
    end
  endtask
  task automatic t_regs;
    bus(1'h0, STATUS_OFFSET, 32'h0);
    `CHK(rd, stv(1'h0, 1'h1, 1'h1, 1'h1))
    bus(1'h0, 8'h08, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(hresp, 1'h0)
    bus(1'h1, CTRL_OFFSET, 32'h1);
    bus(1'h0, CTRL_OFFSET, 32'h0);
    `CHK(rd, 32'h1)
    bus(1'h1, CTRL_OFFSET, 32'h0);
  endtask
  task automatic t_rate(input int e);
    int h, p;
    per(proc_clk, h, p);
    `CHK(p, e)
    `CHK(h * 3, p)
    per(half_clk, h, p);
    `CHK(p, e)
    `CHK(h * 2, p)
    per(per_clk, h, p);
    `CHK(p, 24)
    `CHK(h * 2, p)
  endtask
  task automatic t_block;
    logic h;
    stop_try(3'h5, h);
    `CHK(h, 1'h0)
    start <= 1'h1;
    stop_try(3'h7, h);
    `CHK(h, 1'h0)
    start <= 1'h0;
  endtask
  task automatic t_halt(input int lim, input logic by_rq);
    logic h, pk;
    int n;
    stop_try(3'h7, h);
    `CHK(h, 1'h1)
    pk = per_clk;
    bus(1'h0, STATUS_OFFSET, 32'h0);
    `CHK(rd, stv(1'h1, src, spd, src))
    `CHK({proc_clk, half_clk, per_clk, osc | src}, {2'h3, pk, 1'h1})
    @(posedge clk);
    start <= !by_rq;
    rqn <= !by_rq;
    cyc_to(proc_clk, 1'h0, n);
    start <= 1'h0;
    rqn <= 1'h1;
    `CHK(n <= lim && (src || n >= 4 * SC - 8), 1'h1)
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    errors++;
    end_sim;
  end
  initial begin
    int h, p;
    reset_dut(1'h1);
    t_regs;
    t_rate(12);
    spd <= 1'h0;
    per(proc_clk, h, p);
    t_rate(48);
    t_halt(4 * PS + 12, 1'h0);
    per(proc_clk, h, p);
    `CHK(p, 48)
    spd <= 1'h1;
    per(proc_clk, h, p);
    t_block;
    t_halt(12, 1'h0);
    reset_dut(1'h0);
    t_rate(12);
    t_halt(4 * SC + 40, 1'h0);
    t_halt(4 * SC + 40, 1'h1);
    end_sim;
  end
endmodule // tb
`default_nettype wire
